/* rfl_filter_compare.sv */
// reading filter, output selectors, setpoint and alarm comparators
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - filter type 0 adaptive, 1 fixed
// - adaptive drops to no averaging on steps
// - display shows raw at 0, filtered at 1
// - analog out: raw, filtered, peak, valley
// - averaging length only powers of two
// - fixed uses length; adaptive caps at it
// - setpoint zone bit: above or below
// - setpoint polarity inverts relay output
// - setpoint compares raw or filtered reading
// - shared bit disables both setpoints
// - shared bit disables both setpoint lamps
// - alarm zone bit: above or below
// - alarm polarity inverts relay output
// - alarm compares raw or filtered reading
// - shared bit disables alarms and lamps
// - enable bit lets external input reset alarms
// - filter edits commit on menu advance
// - setpoints use clamped hysteresis band
module rfl_filter_compare (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic sampleValid,
    input wire logic [15:0] sampleData,
    input wire logic editWrite,
    input wire logic editFilterType,
    input wire logic editDisplaySrc,
    input wire logic [1:0] editAnalogOutSrc,
    input wire logic [7:0] editAvgLength,
    input wire logic menuAdvance,
    input wire logic [15:0] sp1Value,
    input wire logic [15:0] sp2Value,
    input wire logic [15:0] al1Value,
    input wire logic [15:0] al2Value,
    input wire logic [13:0] setpointHysteresis,
    input wire logic sp1Zone,
    input wire logic sp1OutPolarity,
    input wire logic sp1SourceSel,
    input wire logic sp2Zone,
    input wire logic sp2OutPolarity,
    input wire logic sp2SourceSel,
    input wire logic setpointsDisable,
    input wire logic setpointLampsDisable,
    input wire logic al1Zone,
    input wire logic al1OutPolarity,
    input wire logic al1SourceSel,
    input wire logic al2Zone,
    input wire logic al2OutPolarity,
    input wire logic al2SourceSel,
    input wire logic alarmsDisable,
    input wire logic extAlarmResetEn,
    input wire logic extAlarmResetIn,
    input wire logic peakValleyClear,
    output logic [15:0] filteredValue,
    output logic [15:0] displayValue,
    output logic [15:0] analogOutValue,
    output logic [15:0] peakValue,
    output logic [15:0] valleyValue,
    output logic sp1Out,
    output logic sp2Out,
    output logic sp1Lamp,
    output logic sp2Lamp,
    output logic al1Out,
    output logic al2Out,
    output logic al1Lamp,
    output logic al2Lamp,
    output logic atAvgLengthItem
);

    typedef struct packed {
        logic pFltType;
        logic pDispSrc;
        logic [1:0] pAoSrc;
        logic [2:0] pLenLog2;
        logic fltType;
        logic dispSrc;
        logic [1:0] aoSrc;
        logic [2:0] lenLog2;
        logic atLenItem;
        logic [2:0] adaptLog2;
        logic [15:0] raw;
        logic [15:0] peak;
        logic [15:0] valley;
        logic pvValid;
        logic [1:0] spAct;
        logic [1:0] alAct;
        logic [15:0] disp;
        logic [15:0] aout;
    } rfl_main_st_t;

    rfl_main_st_t st_ff;
    rfl_main_st_t nxt_st;
    rfl_avg_if avgBus ();
    logic [16:0] stepDiff;
    logic [16:0] stepMag;
    logic [13:0] hystEff;
    logic [15:0] sp1Rd;
    logic [15:0] sp2Rd;
    logic [15:0] al1Rd;
    logic [15:0] al2Rd;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic isPow2(input logic [7:0] n);
        return (n != 8'h00) && ((n & (n - 8'h01)) == 8'h00);
    endfunction

    function automatic logic [2:0] lenToLog2(input logic [7:0] n);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < 8; i++)
        begin
            if (n[i])
                r = 3'(i);
        end
        return r;
    endfunction

    // active state with hysteresis; wide math keeps ends from wrapping
    function automatic logic cmpZone(input logic [15:0] rd,
        input logic [15:0] val, input logic [13:0] hy,
        input logic zone, input logic prev);
        logic signed [17:0] r;
        logic signed [17:0] v;
        logic signed [17:0] h;
        r = 18'(signed'(rd));
        v = 18'(signed'(val));
        h = signed'({4'h0, hy});
        if (zone == rfl_pkg::ZONE_RST)
            return prev ? (r > v - h) : (r > v);
        else
            return prev ? (r < v + h) : (r < v);
    endfunction

    // ------------------------------------------------------------
    // window averager
    // ------------------------------------------------------------
    assign avgBus.sampleValid = sampleValid;
    assign avgBus.sample = sampleData;
    // fixed mode takes the length as is, adaptive uses its own
    assign avgBus.lenLog2 = (st_ff.fltType == rfl_pkg::FLT_FIXED)
        ? st_ff.lenLog2 : st_ff.adaptLog2;

    rfl_window_avg uWin (
        .clk(clk),
        .arst_n(arst_n),
        .port(avgBus.engine)
    );

    // ------------------------------------------------------------
    // comparator inputs
    // ------------------------------------------------------------
    assign stepDiff = {sampleData[15], sampleData}
        - {avgBus.avg[15], avgBus.avg};
    assign stepMag = stepDiff[16] ? (17'h0 - stepDiff) : stepDiff;
    assign hystEff = (setpointHysteresis > rfl_pkg::HYST_MAX)
        ? rfl_pkg::HYST_MAX : setpointHysteresis;
    assign sp1Rd = sp1SourceSel ? avgBus.avg : st_ff.raw;
    assign sp2Rd = sp2SourceSel ? avgBus.avg : st_ff.raw;
    assign al1Rd = al1SourceSel ? avgBus.avg : st_ff.raw;
    assign al2Rd = al2SourceSel ? avgBus.avg : st_ff.raw;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        // pending edits; a bad length leaves the old one in place
        if (editWrite)
        begin
            nxt_st.pFltType = editFilterType;
            nxt_st.pDispSrc = editDisplaySrc;
            nxt_st.pAoSrc = editAnalogOutSrc;
            if (isPow2(editAvgLength))
                nxt_st.pLenLog2 = lenToLog2(editAvgLength);
        end
        // commit includes an edit made in the same cycle
        if (menuAdvance)
        begin
            nxt_st.fltType = nxt_st.pFltType;
            nxt_st.dispSrc = nxt_st.pDispSrc;
            nxt_st.aoSrc = nxt_st.pAoSrc;
            nxt_st.lenLog2 = nxt_st.pLenLog2;
            nxt_st.atLenItem = !st_ff.atLenItem;
        end
        if (sampleValid)
        begin
            nxt_st.raw = sampleData;
            // a big step restarts averaging; steady input widens it
            if (stepMag > rfl_pkg::ABC_STEP)
                nxt_st.adaptLog2 = 3'h0;
            else if (st_ff.adaptLog2 < st_ff.lenLog2)
                nxt_st.adaptLog2 = st_ff.adaptLog2 + 3'h1;
            else
                nxt_st.adaptLog2 = st_ff.lenLog2;
        end
        // a shorter committed length caps the adaptive one at once
        if (nxt_st.adaptLog2 > nxt_st.lenLog2)
            nxt_st.adaptLog2 = nxt_st.lenLog2;
        // clear with a reading in the same cycle restarts from it
        if (peakValleyClear)
            nxt_st.pvValid = 1'b0;
        if (sampleValid)
        begin
            if (peakValleyClear || !st_ff.pvValid)
            begin
                nxt_st.peak = sampleData;
                nxt_st.valley = sampleData;
            end
            else
            begin
                if ($signed(sampleData) > $signed(st_ff.peak))
                    nxt_st.peak = sampleData;
                if ($signed(sampleData) < $signed(st_ff.valley))
                    nxt_st.valley = sampleData;
            end
            nxt_st.pvValid = 1'b1;
        end
        nxt_st.spAct[0] = cmpZone(sp1Rd, sp1Value, hystEff, sp1Zone,
            st_ff.spAct[0]);
        nxt_st.spAct[1] = cmpZone(sp2Rd, sp2Value, hystEff, sp2Zone,
            st_ff.spAct[1]);
        // alarm band is not applied here, so hysteresis is zero
        nxt_st.alAct[0] = cmpZone(al1Rd, al1Value, 14'h0, al1Zone,
            st_ff.alAct[0]);
        nxt_st.alAct[1] = cmpZone(al2Rd, al2Value, 14'h0, al2Zone,
            st_ff.alAct[1]);
        if (extAlarmResetEn && extAlarmResetIn)
            nxt_st.alAct = 2'h0;
        nxt_st.disp = st_ff.dispSrc ? avgBus.avg : st_ff.raw;
        unique case (st_ff.aoSrc)
            rfl_pkg::AO_RAW: nxt_st.aout = st_ff.raw;
            rfl_pkg::AO_FILT: nxt_st.aout = avgBus.avg;
            rfl_pkg::AO_PEAK: nxt_st.aout = st_ff.peak;
            rfl_pkg::AO_VALLEY: nxt_st.aout = st_ff.valley;
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_ff <= '0;
            st_ff.pFltType <= rfl_pkg::FLT_TYPE_RST;
            st_ff.pDispSrc <= rfl_pkg::DISP_SRC_RST;
            st_ff.pAoSrc <= rfl_pkg::AO_SRC_RST;
            st_ff.pLenLog2 <= rfl_pkg::LEN_LOG2_RST;
            st_ff.fltType <= rfl_pkg::FLT_TYPE_RST;
            st_ff.dispSrc <= rfl_pkg::DISP_SRC_RST;
            st_ff.aoSrc <= rfl_pkg::AO_SRC_RST;
            st_ff.lenLog2 <= rfl_pkg::LEN_LOG2_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // outputs; disabled relays are held off regardless of polarity
    // ------------------------------------------------------------
    assign filteredValue = avgBus.avg;
    assign displayValue = st_ff.disp;
    assign analogOutValue = st_ff.aout;
    assign peakValue = st_ff.peak;
    assign valleyValue = st_ff.valley;
    assign atAvgLengthItem = st_ff.atLenItem;
    assign sp1Out = !setpointsDisable
        && (st_ff.spAct[0] ^ sp1OutPolarity);
    assign sp2Out = !setpointsDisable
        && (st_ff.spAct[1] ^ sp2OutPolarity);
    assign sp1Lamp = !setpointsDisable && !setpointLampsDisable
        && st_ff.spAct[0];
    assign sp2Lamp = !setpointsDisable && !setpointLampsDisable
        && st_ff.spAct[1];
    assign al1Out = !alarmsDisable
        && (st_ff.alAct[0] ^ al1OutPolarity);
    assign al2Out = !alarmsDisable
        && (st_ff.alAct[1] ^ al2OutPolarity);
    assign al1Lamp = !alarmsDisable && st_ff.alAct[0];
    assign al2Lamp = !alarmsDisable && st_ff.alAct[1];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_fixed_len:
    assert property (@(posedge clk) disable iff (!arst_n)
        st_ff.fltType == rfl_pkg::FLT_FIXED
        |-> avgBus.lenLog2 == st_ff.lenLog2)
    else $error("fixed filter not using selected length");

    a_adapt_cap:
    assert property (@(posedge clk) disable iff (!arst_n)
        st_ff.fltType == rfl_pkg::FLT_ADAPTIVE
        && !menuAdvance |=> avgBus.lenLog2 <= st_ff.lenLog2)
    else $error("adaptive length above selected limit");

    a_adapt_drop:
    assert property (@(posedge clk) disable iff (!arst_n)
        sampleValid && stepMag > rfl_pkg::ABC_STEP
        |=> st_ff.adaptLog2 == 3'h0)
    else $error("adaptive filter kept averaging over a step");

    a_disp_src:
    assert property (@(posedge clk) disable iff (!arst_n)
        1'b1 |=> displayValue
        == $past(st_ff.dispSrc ? avgBus.avg : st_ff.raw))
    else $error("display source wrong");

    a_ao_peak:
    assert property (@(posedge clk) disable iff (!arst_n)
        st_ff.aoSrc == rfl_pkg::AO_PEAK |=> analogOutValue
        == $past(st_ff.peak))
    else $error("analog output not showing peak");

    a_commit_hold:
    assert property (@(posedge clk) disable iff (!arst_n)
        !menuAdvance |=> $stable(st_ff.fltType)
        && $stable(st_ff.lenLog2) && $stable(st_ff.aoSrc))
    else $error("active filter setting changed without commit");

    a_bad_len:
    assert property (@(posedge clk) disable iff (!arst_n)
        editWrite && !isPow2(editAvgLength)
        |=> $stable(st_ff.pLenLog2))
    else $error("invalid averaging length accepted");

    a_sp_disable:
    assert property (@(posedge clk) disable iff (!arst_n)
        setpointsDisable |-> !sp1Out && !sp2Out && !sp1Lamp && !sp2Lamp)
    else $error("disabled setpoints still driving");

    a_al_disable:
    assert property (@(posedge clk) disable iff (!arst_n)
        alarmsDisable |-> !al1Out && !al2Out && !al1Lamp && !al2Lamp)
    else $error("disabled alarms still driving");

    a_ext_reset:
    assert property (@(posedge clk) disable iff (!arst_n)
        extAlarmResetEn && extAlarmResetIn |=> st_ff.alAct == 2'h0)
    else $error("external reset did not clear alarms");

    a_peak_order:
    assert property (@(posedge clk) disable iff (!arst_n)
        st_ff.pvValid |-> $signed(st_ff.peak) >= $signed(st_ff.valley))
    else $error("peak below valley");

endmodule
`default_nettype wire

/* rfl_pkg.sv */
// shared constants for the reading filter and limit compare block
package rfl_pkg;

    // ------------------------------------------------------------
    // data widths and history depth
    // ------------------------------------------------------------
    localparam int RD_W = 16;
    localparam int SUM_W = 24;
    localparam int HIST_DEPTH = 128;
    localparam int PTR_W = 7;
    localparam int HYST_W = 14;

    // ------------------------------------------------------------
    // values after reset (factory presets)
    // ------------------------------------------------------------
    localparam logic FLT_TYPE_RST = 1'h0;
    localparam logic DISP_SRC_RST = 1'h1;
    localparam logic [1:0] AO_SRC_RST = 2'h1;
    localparam logic [2:0] LEN_LOG2_RST = 3'h6;
    localparam logic ZONE_RST = 1'h0;

    // ------------------------------------------------------------
    // selector codes and limits
    // ------------------------------------------------------------
    localparam logic FLT_ADAPTIVE = 1'h0;
    localparam logic FLT_FIXED = 1'h1;
    localparam logic [1:0] AO_RAW = 2'h0;
    localparam logic [1:0] AO_FILT = 2'h1;
    localparam logic [1:0] AO_PEAK = 2'h2;
    localparam logic [1:0] AO_VALLEY = 2'h3;
    localparam logic [13:0] HYST_MAX = 14'h270f;
    // step size that counts as a systematic input change
    localparam logic [16:0] ABC_STEP = 17'h00040;

endpackage

/* rfl_avg_if.sv */
// link between the control logic and the window averager
`timescale 1ns/100ps
`default_nettype none
interface rfl_avg_if;
    logic sampleValid;
    logic [15:0] sample;
    logic [2:0] lenLog2;
    logic avgValid;
    logic [15:0] avg;
    modport requester (output sampleValid, sample, lenLog2,
        input avgValid, avg);
    modport engine (input sampleValid, sample, lenLog2,
        output avgValid, avg);
endinterface
`default_nettype wire

/* rfl_window_avg.sv */
// sliding window averager over the most recent readings
`timescale 1ns/100ps
`default_nettype none
module rfl_window_avg (
    input wire logic clk,
    input wire logic arst_n,
    rfl_avg_if.engine port
);

    typedef struct packed {
        logic [rfl_pkg::HIST_DEPTH-1:0][rfl_pkg::RD_W-1:0] hist;
        logic [rfl_pkg::PTR_W-1:0] wrPtr;
        logic [7:0] fill;
        logic calc;
        logic avgValid;
        logic [rfl_pkg::RD_W-1:0] avg;
    } rfl_win_st_t;

    rfl_win_st_t st_ff;
    rfl_win_st_t nxt_st;
    logic signed [rfl_pkg::SUM_W-1:0] sum;
    logic [2:0] eff;
    logic [rfl_pkg::PTR_W-1:0] idx;

    function automatic logic [2:0] floorLog2(input logic [7:0] n);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < 8; i++)
        begin
            if (n[i])
                r = 3'(i);
        end
        return r;
    endfunction

    // write ring, then average the newest 2^eff entries a cycle later
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.calc = 1'b0;
        nxt_st.avgValid = 1'b0;
        sum = '0;
        idx = '0;
        // young history: never average entries not yet written
        eff = (port.lenLog2 < floorLog2(st_ff.fill)) ? port.lenLog2
            : floorLog2(st_ff.fill);
        if (port.sampleValid)
        begin
            nxt_st.hist[st_ff.wrPtr] = port.sample;
            nxt_st.wrPtr = st_ff.wrPtr + 7'h1;
            if (st_ff.fill != 8'h80)
                nxt_st.fill = st_ff.fill + 8'h01;
            nxt_st.calc = 1'b1;
        end
        if (st_ff.calc)
        begin
            for (int k = 0; k < rfl_pkg::HIST_DEPTH; k++)
            begin
                idx = st_ff.wrPtr - 7'(k + 1);
                if (k < (1 << eff))
                    sum = sum + 24'(signed'(st_ff.hist[idx]));
            end
            nxt_st.avg = 16'(sum >>> eff);
            nxt_st.avgValid = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign port.avgValid = st_ff.avgValid;
    assign port.avg = st_ff.avg;

    a_avg_follows:
    assert property (@(posedge clk) disable iff (!arst_n)
        port.sampleValid |=> ##1 port.avgValid)
    else $error("average did not follow a reading by two cycles");

    a_len_zero_raw:
    assert property (@(posedge clk) disable iff (!arst_n)
        st_ff.calc && port.lenLog2 == 3'h0
        |=> port.avg == $past(st_ff.hist[st_ff.wrPtr - 7'h1]))
    else $error("zero averaging did not pass the newest reading");

endmodule
`default_nettype wire

/* rfl_panel_model.sv */
// operator panel model: stages filter edits, then commits them
`timescale 1ns/100ps
`default_nettype none
module rfl_panel_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic go,
    input wire logic [11:0] req,
    output logic editWrite,
    output logic editFilterType,
    output logic editDisplaySrc,
    output logic [1:0] editAnalogOutSrc,
    output logic [7:0] editAvgLength,
    output logic menuAdvance
);
    // ------------------------------------------------------------
    // edit cycle, then menu advance one cycle later
    // ------------------------------------------------------------
    // fields are inverted outside the edit cycle, so stale values
    // can never pass for a request that is still held
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            editWrite <= 1'h0;
            menuAdvance <= 1'h0;
            {editFilterType, editDisplaySrc, editAnalogOutSrc,
                editAvgLength} <= 12'h000;
        end
        else
        begin
            editWrite <= go;
            menuAdvance <= editWrite;
            {editFilterType, editDisplaySrc, editAnalogOutSrc,
                editAvgLength} <= go ? req : ~req;
        end
    end
endmodule
`default_nettype wire

/* rfl_filter_compare_test.sv */
// self-checking bench for the reading filter and limit compare block
`timescale 1ns/100ps
`default_nettype none
module rfl_filter_compare_test;
    logic clk = 1'h0;
    logic arst_n = 1'h0;
    logic sampleValid = 1'h0;
    logic [15:0] sampleData = 16'h0000;
    logic go = 1'h0;
    logic [11:0] req = 12'h000;
    logic [15:0] lim [4] = '{16'h03e8, 16'h0384, 16'h044c, 16'h03e8};
    logic [13:0] hyst = 14'h0000;
    logic [3:0] zone = 4'h0;
    logic [3:0] pol = 4'h0;
    logic [3:0] src = 4'hf;
    logic spDis = 1'h0;
    logic lampDis = 1'h0;
    logic alDis = 1'h0;
    logic extEn = 1'h0;
    logic extIn = 1'h0;
    logic pvClear = 1'h0;
    logic expItem = 1'h0;
    wire editWrite, editFilterType, editDisplaySrc, menuAdvance, item;
    wire [1:0] editAnalogOutSrc;
    wire [7:0] editAvgLength;
    wire [15:0] filteredValue, displayValue, analogOutValue;
    wire [15:0] peakValue, valleyValue;
    wire [3:0] outs, lamps;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    int seed;
    int pk;
    int vl;
    int hist [$];
    int hv [3] = '{16'h03f2, 16'h03de, 16'h03ca};

    rfl_panel_model panel (.clk, .arst_n, .go, .req, .editWrite,
        .editFilterType, .editDisplaySrc, .editAnalogOutSrc,
        .editAvgLength, .menuAdvance);

    rfl_filter_compare DUT (.clk, .arst_n, .sampleValid, .sampleData,
        .editWrite, .editFilterType, .editDisplaySrc, .editAnalogOutSrc,
        .editAvgLength, .menuAdvance, .sp1Value(lim[0]),
        .sp2Value(lim[1]), .al1Value(lim[2]), .al2Value(lim[3]),
        .setpointHysteresis(hyst), .sp1Zone(zone[0]),
        .sp1OutPolarity(pol[0]), .sp1SourceSel(src[0]),
        .sp2Zone(zone[1]), .sp2OutPolarity(pol[1]),
        .sp2SourceSel(src[1]), .setpointsDisable(spDis),
        .setpointLampsDisable(lampDis), .al1Zone(zone[2]),
        .al1OutPolarity(pol[2]), .al1SourceSel(src[2]),
        .al2Zone(zone[3]), .al2OutPolarity(pol[3]),
        .al2SourceSel(src[3]), .alarmsDisable(alDis),
        .extAlarmResetEn(extEn), .extAlarmResetIn(extIn),
        .peakValleyClear(pvClear), .filteredValue, .displayValue,
        .analogOutValue, .peakValue, .valleyValue, .sp1Out(outs[0]),
        .sp2Out(outs[1]), .sp1Lamp(lamps[0]), .sp2Lamp(lamps[1]),
        .al1Out(outs[2]), .al2Out(outs[3]), .al1Lamp(lamps[2]),
        .al2Lamp(lamps[3]), .atAvgLengthItem(item));

    // ------------------------------------------------------------
    // clock, hang guard and reporting
    // ------------------------------------------------------------
    // free-running 50 ns clock
    initial
    begin
        forever #25 clk = ~clk;
    end

    // the whole run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // ------------------------------------------------------------
    // drivers and expectation helpers
    // ------------------------------------------------------------
    // the extra 1 ns lets register updates land before sampling
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    function automatic int avgLast(input int n);
        int s = 0;
        for (int i = 1; i <= n; i++)
            s += hist[hist.size() - i];
        return s / n;
    endfunction

    // valid stays up so back-to-back readings need no gap
    task automatic feed(input int r, input logic clr);
        @(posedge clk);
        sampleValid <= 1'h1;
        sampleData <= 16'(r);
        pvClear <= clr;
        hist.push_back(r);
        if (clr || r > pk)
            pk = r;
        if (clr || r < vl)
            vl = r;
    endtask

    task automatic idle;
        @(posedge clk);
        sampleValid <= 1'h0;
        pvClear <= 1'h0;
        tick(6);
    endtask

    task automatic feed4(input logic clr);
        for (int i = 0; i < 4; i++)
            feed($urandom_range(16'h0fa0, 0), clr && i == 0);
        idle();
    endtask

    task automatic commit(input logic [11:0] r);
        @(posedge clk);
        go <= 1'h1;
        req <= r;
        @(posedge clk);
        go <= 1'h0;
        tick(5);
        expItem = ~expItem;
        check(16'(item), 16'(expItem));
    endtask

    task automatic cmpChk;
        int r;
        logic act;
        for (int k = 0; k < 4; k++)
        begin
            r = src[k] ? avgLast(4) : hist[$];
            act = zone[k] ? (r < lim[k]) : (r > lim[k]);
            if (k < 2)
            begin
                check(16'(outs[k]), 16'(!spDis && (act ^ pol[k])));
                check(16'(lamps[k]), 16'(act && !spDis && !lampDis));
            end
            else
            begin
                check(16'(outs[k]), 16'(!alDis && (act ^ pol[k])));
                check(16'(lamps[k]), 16'(act && !alDis));
            end
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        seed = $urandom(39);
        @(posedge clk);
        pol[0] <= 1'h1;
        repeat (9) @(posedge clk);
        check(16'(outs[0]), 16'h0001);
        check(displayValue, 16'h0000);
        arst_n <= 1'h1;
        pol <= 4'h0;
        repeat (100) feed(16'h03e8, 1'h0);
        idle();
        check(filteredValue, 16'h03e8);
        feed(16'h07d0, 1'h0);
        idle();
        check(filteredValue, 16'h07d0);
        check(displayValue, 16'h07d0);
        check(analogOutValue, 16'h07d0);
        $display("test adaptive done");
        commit({1'h1, 1'h1, 2'h1, 8'h04});
        feed4(1'h1);
        check(filteredValue, 16'(avgLast(4)));
        commit({1'h1, 1'h0, 2'h1, 8'h03});
        feed4(1'h0);
        check(filteredValue, 16'(avgLast(4)));
        check(displayValue, 16'(hist[$]));
        check(peakValue, 16'(pk));
        check(valleyValue, 16'(vl));
        for (int a = 0; a < 4; a++)
        begin
            commit({1'h1, 1'h0, 2'(a), 8'h04});
            check(analogOutValue, 16'(a == 0 ? hist[$] : a == 1 ?
                avgLast(4) : a == 2 ? pk : vl));
        end
        $display("test fixed average done");
        for (int i = 0; i < 12; i++)
        begin
            @(posedge clk);
            zone <= 4'($urandom);
            pol <= 4'($urandom);
            src <= 4'($urandom);
            spDis <= ($urandom_range(3, 0) == 0);
            lampDis <= ($urandom_range(3, 0) == 0);
            alDis <= ($urandom_range(3, 0) == 0);
            feed($urandom_range(16'h07d0, 0), 1'h0);
            idle();
            cmpChk();
        end
        @(posedge clk);
        {zone, pol, src, spDis, lampDis, alDis} <= '0;
        extEn <= 1'h1;
        extIn <= 1'h1;
        feed(16'h05dc, 1'h0);
        idle();
        check(16'(outs[2]), 16'h0000);
        @(posedge clk);
        extEn <= 1'h0;
        tick(3);
        check(16'(outs[2]), 16'h0001);
        $display("test comparators done");
        @(posedge clk);
        extIn <= 1'h0;
        hyst <= 14'h0014;
        for (int j = 0; j < 3; j++)
        begin
            feed(hv[j], 1'h0);
            idle();
            check(16'(outs[0]), 16'(j < 2));
        end
        // an oversized band must clamp, so a deep dip still releases
        @(posedge clk);
        hyst <= 14'h3fff;
        feed(16'h05dc, 1'h0);
        idle();
        check(16'(outs[0]), 16'h0001);
        feed(-10000, 1'h0);
        idle();
        check(16'(outs[0]), 16'h0000);
        $display("test hysteresis done");
        wrap_up();
    end
endmodule
`default_nettype wire
